// *** rtl/cmo_pkg.sv ***
// constants, field layouts and types of the message-object store
// assumes a word-addressed register port and an external frame engine
package cmo_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int          NUM_OBJ   = 32;
  localparam int          ADDR_W    = 9;
  localparam int          ID_W      = 29;
  localparam int          DATA_W    = 64;
  localparam logic [7:0]  WARN_LVL  = 8'h60;       // error counter warning level
  localparam logic [28:0] STD_ID_M  = 29'h000007FF;
  localparam logic [28:0] EXT_ID_M  = 29'h1FFFFFFF;

  // ----------------------------------------------------------------
  // address map: addr[8]=0 selects object addr[7:3], field addr[2:0]
  // ----------------------------------------------------------------
  localparam int         GLOBAL_BIT = 8;
  localparam logic [2:0] OF_CONFIG  = 3'h0;
  localparam logic [2:0] OF_ID      = 3'h1;
  localparam logic [2:0] OF_MASK    = 3'h2;
  localparam logic [2:0] OF_DATA_LO = 3'h3;
  localparam logic [2:0] OF_DATA_HI = 3'h4;
  localparam logic [2:0] GR_CTRL    = 3'h0;
  localparam logic [2:0] GR_STATUS  = 3'h1;
  localparam logic [2:0] GR_PEND    = 3'h2;
  localparam logic [2:0] GR_FRESH   = 3'h3;
  localparam logic [2:0] GR_VALID   = 3'h4;
  localparam logic [2:0] GR_INTID   = 3'h5;
  localparam logic [2:0] GR_INTCLR  = 3'h6;
  localparam logic [2:0] GR_INTMAP  = 3'h7;

  // config word fields
  localparam int CF_VALID = 0;
  localparam int CF_KIND  = 1;   // 3 bits
  localparam int CF_EXT   = 4;
  localparam int CF_FILT  = 5;
  localparam int CF_TXIE  = 6;
  localparam int CF_RXIE  = 7;
  localparam int CF_DLC   = 8;   // 4 bits
  localparam int CF_PEND  = 12;
  localparam int CF_FRESH = 13;
  localparam int CF_LOST  = 14;
  localparam int CF_IRQ   = 15;

  // control and status word fields
  localparam int CT_ENABLE = 0;
  localparam int CT_RETRY  = 1;
  localparam int ST_LEC    = 0;  // 3 bits
  localparam int ST_TXOK   = 3;
  localparam int ST_RXOK   = 4;
  localparam int ST_EPASS  = 5;
  localparam int ST_EWARN  = 6;
  localparam int ST_BOFF   = 7;

  localparam logic [15:0] STATUS_INTERRUPT_CODE = 16'h8000;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OBJECT_KIND_SEND_DATA      = 3'h0,
    OBJECT_KIND_SEND_REQUEST   = 3'h1,
    OBJECT_KIND_TAKE_DATA      = 3'h2,
    OBJECT_KIND_TAKE_REQUEST   = 3'h3,
    OBJECT_KIND_AUTO_RESPONDER = 3'h4
  } cmo_kind_e;

  localparam logic [2:0] LAST_ERROR_NONE           = 3'h0;
  localparam logic [2:0] LAST_ERROR_STUFFING       = 3'h1;
  localparam logic [2:0] LAST_ERROR_FORMAT         = 3'h2;
  localparam logic [2:0] LAST_ERROR_NO_ACKNOWLEDGE = 3'h3;
  localparam logic [2:0] LAST_ERROR_BIT_ONE        = 3'h4;
  localparam logic [2:0] LAST_ERROR_BIT_ZERO       = 3'h5;
  localparam logic [2:0] LAST_ERROR_CHECKSUM       = 3'h6;

  typedef enum logic {TX_IDLE, TX_BUSY} cmo_tx_e;

endpackage

// *** rtl/cmo_core.sv ***
// message-object store, status word and summary bitmaps of a can controller
// assumes a frame engine that hands over received frames as one-cycle pulses
// and takes one transmit request at a time; software uses the register port
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

module cmo_core (
  // clock and reset
  input  wire  logic                        core_clk_i,
  input  wire  logic                        nrst_i,
  // register port
  input  wire  logic [cmo_pkg::ADDR_W-1:0]  addr_i,
  input  wire  logic [31:0]                 wr_data_i,
  input  wire  logic                        wr_i,
  input  wire  logic                        rd_i,
  output logic       [31:0]                 rd_data_o,
  // received frame from the frame engine
  input  wire  logic                        rx_valid_i,
  input  wire  logic [cmo_pkg::ID_W-1:0]    rx_id_i,
  input  wire  logic                        rx_ext_i,
  input  wire  logic                        rx_remote_i,
  input  wire  logic [3:0]                  rx_dlc_i,
  input  wire  logic [cmo_pkg::DATA_W-1:0]  rx_data_i,
  // transmit request to the frame engine
  output logic                              tx_req_o,
  output logic       [cmo_pkg::ID_W-1:0]    tx_id_o,
  output logic                              tx_ext_o,
  output logic                              tx_remote_o,
  output logic       [3:0]                  tx_dlc_o,
  output logic       [cmo_pkg::DATA_W-1:0]  tx_data_o,
  input  wire  logic                        tx_done_i,
  input  wire  logic                        tx_fail_i,
  // error state from the frame engine
  input  wire  logic                        bus_off_i,
  input  wire  logic                        err_passive_i,
  input  wire  logic [7:0]                  tx_err_cnt_i,
  input  wire  logic [7:0]                  rx_err_cnt_i,
  input  wire  logic                        err_valid_i,
  input  wire  logic [2:0]                  err_code_i,
  input  wire  logic                        bit_err_i,
  input  wire  logic                        bit_sent_recessive_i,
  // controller state
  output logic                              enabled_o,
  output logic       [15:0]                 irq_id_o
);
  import cmo_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                valid;
    cmo_kind_e           kind;
    logic                ext;
    logic                filt;
    logic                txie;
    logic                rxie;
    logic [3:0]          dlc;
    logic [ID_W-1:0]     id;
    logic [ID_W-1:0]     mask;
    logic [DATA_W-1:0]   data;
    logic                pend;
    logic                fresh;
    logic                lost;
    logic                irq;
  } cmo_obj_s;

  typedef struct packed {
    cmo_obj_s [NUM_OBJ-1:0] obj;
    logic                   enable;
    logic                   retry;
    logic                   boff;
    logic                   epass;
    logic                   ewarn;
    logic                   rxok;
    logic                   txok;
    logic [2:0]             lec;
    logic                   stat_irq;
    cmo_tx_e                tx_st;
    logic [4:0]             tx_idx;
    logic                   tx_req;
    logic [ID_W-1:0]        tx_id;
    logic                   tx_ext;
    logic                   tx_remote;
    logic [3:0]             tx_dlc;
    logic [DATA_W-1:0]      tx_data;
    logic [31:0]            rd_data;
    logic [15:0]            irq_id;
  } cmo_state_s;

  cmo_state_s st_reg;
  cmo_state_s st_next;

  // identifier compare of one object against the received frame
  function automatic logic id_hit(input cmo_obj_s o, input logic [ID_W-1:0] rid, input logic rext);
    logic [ID_W-1:0] m;
    m = rext ? EXT_ID_M : STD_ID_M;
    if (o.filt) begin
      m = m & o.mask;
    end
    return (o.ext == rext) && (((o.id ^ rid) & m) == '0);
  endfunction

  // does this object take a frame of this type
  function automatic logic kind_hit(input cmo_obj_s o, input logic remote);
    logic r;
    r = 1'b0;
    unique case (o.kind)
      OBJECT_KIND_TAKE_DATA, OBJECT_KIND_SEND_REQUEST:   r = !remote;
      OBJECT_KIND_TAKE_REQUEST, OBJECT_KIND_AUTO_RESPONDER: r = remote;
      default:                                            r = 1'b0;
    endcase
    return o.valid && r;
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [4:0]  oi;
    logic        hit;
    logic [4:0]  hit_idx;
    logic        found;
    logic [4:0]  pick;
    logic [31:0] rv;
    logic [31:0] map;
    logic [15:0] iid;
    logic [5:0]  num;
    oi      = addr_i[7:3];
    hit     = 1'b0;
    hit_idx = '0;
    found   = 1'b0;
    pick    = '0;
    rv      = '0;
    map     = '0;
    iid     = '0;
    num     = '0;
    st_next = st_reg;

    // error state is followed every cycle
    st_next.boff  = bus_off_i;
    st_next.epass = err_passive_i;
    st_next.ewarn = (tx_err_cnt_i >= WARN_LVL) || (rx_err_cnt_i >= WARN_LVL);

    // register reads: data stand only in the cycle after the strobe
    if (rd_i) begin
      if (!addr_i[GLOBAL_BIT]) begin
        unique case (addr_i[2:0])
          OF_CONFIG: begin
            rv[CF_VALID]          = st_reg.obj[oi].valid;
            rv[CF_KIND+:3]        = st_reg.obj[oi].kind;
            rv[CF_EXT]            = st_reg.obj[oi].ext;
            rv[CF_FILT]           = st_reg.obj[oi].filt;
            rv[CF_TXIE]           = st_reg.obj[oi].txie;
            rv[CF_RXIE]           = st_reg.obj[oi].rxie;
            rv[CF_DLC+:4]         = st_reg.obj[oi].dlc;
            rv[CF_PEND]           = st_reg.obj[oi].pend;
            rv[CF_FRESH]          = st_reg.obj[oi].fresh;
            rv[CF_LOST]           = st_reg.obj[oi].lost;
            rv[CF_IRQ]            = st_reg.obj[oi].irq;
          end
          OF_ID:      rv[ID_W-1:0] = st_reg.obj[oi].id;
          OF_MASK:    rv[ID_W-1:0] = st_reg.obj[oi].mask;
          OF_DATA_LO: rv = st_reg.obj[oi].data[31:0];
          OF_DATA_HI: begin
            rv = st_reg.obj[oi].data[63:32];
            // collecting the payload ends its fresh state and its interrupt
            st_next.obj[oi].fresh = 1'b0;
            st_next.obj[oi].lost  = 1'b0;
            st_next.obj[oi].irq   = 1'b0;
          end
          default: rv = '0;
        endcase
      end else begin
        for (int i = 0; i < NUM_OBJ; i++) begin
          unique case (addr_i[2:0])
            GR_PEND:   map[i] = st_reg.obj[i].pend;
            GR_FRESH:  map[i] = st_reg.obj[i].fresh;
            GR_VALID:  map[i] = st_reg.obj[i].valid;
            GR_INTMAP: map[i] = st_reg.obj[i].irq;
            default:   map[i] = 1'b0;
          endcase
        end
        unique case (addr_i[2:0])
          GR_CTRL: begin
            rv[CT_ENABLE] = st_reg.enable;
            rv[CT_RETRY]  = st_reg.retry;
          end
          GR_STATUS: begin
            rv[ST_LEC+:3] = st_reg.lec;
            rv[ST_TXOK]   = st_reg.txok;
            rv[ST_RXOK]   = st_reg.rxok;
            rv[ST_EPASS]  = st_reg.epass;
            rv[ST_EWARN]  = st_reg.ewarn;
            rv[ST_BOFF]   = st_reg.boff;
            st_next.stat_irq = 1'b0;
          end
          GR_INTID: rv[15:0] = st_reg.irq_id;
          default:  rv = map;
        endcase
      end
    end
    st_next.rd_data = rv;

    // register writes
    if (wr_i) begin
      if (!addr_i[GLOBAL_BIT]) begin
        unique case (addr_i[2:0])
          OF_CONFIG: begin
            // a new configuration clears the fresh, lost and irq flags; id, mask and data stay
            st_next.obj[oi].valid = wr_data_i[CF_VALID];
            st_next.obj[oi].kind  = cmo_kind_e'(wr_data_i[CF_KIND+:3]);
            st_next.obj[oi].ext   = wr_data_i[CF_EXT];
            st_next.obj[oi].filt  = wr_data_i[CF_FILT];
            st_next.obj[oi].txie  = wr_data_i[CF_TXIE];
            st_next.obj[oi].rxie  = wr_data_i[CF_RXIE];
            st_next.obj[oi].dlc   = wr_data_i[CF_DLC+:4];
            st_next.obj[oi].pend  = wr_data_i[CF_PEND] & wr_data_i[CF_VALID];
            st_next.obj[oi].fresh = 1'b0;
            st_next.obj[oi].lost  = 1'b0;
            st_next.obj[oi].irq   = 1'b0;
          end
          OF_ID:      st_next.obj[oi].id   = wr_data_i[ID_W-1:0];
          OF_MASK:    st_next.obj[oi].mask = wr_data_i[ID_W-1:0];
          OF_DATA_LO: st_next.obj[oi].data[31:0]  = wr_data_i;
          OF_DATA_HI: st_next.obj[oi].data[63:32] = wr_data_i;
          default: ;
        endcase
      end else begin
        unique case (addr_i[2:0])
          GR_CTRL: begin
            st_next.enable = wr_data_i[CT_ENABLE];
            st_next.retry  = wr_data_i[CT_RETRY];
          end
          GR_STATUS: begin
            // lets software clear the sticky success flags and error code
            st_next.lec  = wr_data_i[ST_LEC+:3];
            st_next.txok = wr_data_i[ST_TXOK];
            st_next.rxok = wr_data_i[ST_RXOK];
          end
          GR_INTCLR: begin
            num = wr_data_i[5:0];
            if (wr_data_i[15:0] == STATUS_INTERRUPT_CODE) begin
              st_next.stat_irq = 1'b0;
            end else if (wr_data_i[15:6] == '0 && num != '0 && num <= 6'(NUM_OBJ)) begin
              st_next.obj[5'(num - 6'h01)].irq = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end

    // frame engine events come after the software clears, so a set wins
    if (st_reg.enable && err_valid_i) begin
      st_next.lec      = err_code_i;
      st_next.stat_irq = 1'b1;
    end
    if (st_reg.enable && bit_err_i) begin
      st_next.lec      = bit_sent_recessive_i ? LAST_ERROR_BIT_ONE : LAST_ERROR_BIT_ZERO;
      st_next.stat_irq = 1'b1;
    end

    // reception: the lowest numbered matching object takes the frame
    if (st_reg.enable && rx_valid_i) begin
      st_next.rxok     = 1'b1;
      st_next.stat_irq = 1'b1;
      for (int i = NUM_OBJ - 1; i >= 0; i--) begin
        if (kind_hit(st_reg.obj[i], rx_remote_i) && id_hit(st_reg.obj[i], rx_id_i, rx_ext_i)) begin
          hit     = 1'b1;
          hit_idx = 5'(i);
        end
      end
      if (hit) begin
        if (st_reg.obj[hit_idx].kind == OBJECT_KIND_AUTO_RESPONDER) begin
          st_next.obj[hit_idx].pend = 1'b1;
        end else begin
          st_next.obj[hit_idx].lost  = st_next.obj[hit_idx].lost | st_reg.obj[hit_idx].fresh;
          st_next.obj[hit_idx].fresh = 1'b1;
          if (!rx_remote_i) begin
            st_next.obj[hit_idx].data = rx_data_i;
            st_next.obj[hit_idx].dlc  = rx_dlc_i;
          end
          if (st_reg.obj[hit_idx].kind == OBJECT_KIND_SEND_REQUEST) begin
            st_next.obj[hit_idx].pend = 1'b0;              // answer arrived
          end
        end
        st_next.obj[hit_idx].irq = st_next.obj[hit_idx].irq | st_reg.obj[hit_idx].rxie;
      end
    end

    // transmission: one frame at a time, lowest numbered pending object first
    unique case (st_reg.tx_st)
      TX_IDLE: begin
        for (int i = NUM_OBJ - 1; i >= 0; i--) begin
          if (st_reg.obj[i].valid && st_reg.obj[i].pend) begin
            found = 1'b1;
            pick  = 5'(i);
          end
        end
        if (st_reg.enable && found) begin
          st_next.tx_st     = TX_BUSY;
          st_next.tx_idx    = pick;
          st_next.tx_req    = 1'b1;
          st_next.tx_id     = st_reg.obj[pick].id;
          st_next.tx_ext    = st_reg.obj[pick].ext;
          st_next.tx_remote = st_reg.obj[pick].kind == OBJECT_KIND_SEND_REQUEST;
          st_next.tx_dlc    = st_reg.obj[pick].dlc;
          st_next.tx_data   = st_reg.obj[pick].data;
        end
      end
      TX_BUSY: begin
        if (tx_done_i) begin
          st_next.tx_st = TX_IDLE;
          st_next.tx_req = 1'b0;
          st_next.txok = 1'b1;
          st_next.stat_irq = 1'b1;
          if (st_reg.obj[st_reg.tx_idx].valid) begin
            st_next.obj[st_reg.tx_idx].pend = 1'b0;
            st_next.obj[st_reg.tx_idx].irq  = st_next.obj[st_reg.tx_idx].irq | st_reg.obj[st_reg.tx_idx].txie;
          end
        end else if (tx_fail_i) begin
          // with retry the object stays pending and is picked again
          st_next.tx_st  = TX_IDLE;
          st_next.tx_req = 1'b0;
          if (!st_reg.retry) begin
            st_next.obj[st_reg.tx_idx].pend = 1'b0;
          end
        end else if (!st_reg.obj[st_reg.tx_idx].valid || !st_reg.enable) begin
          // the engine may already be mid-frame; only the request is withdrawn
          st_next.tx_st  = TX_IDLE;
          st_next.tx_req = 1'b0;
        end
      end
    endcase

    // interrupt identification from the present flags
    for (int i = NUM_OBJ - 1; i >= 0; i--) begin
      if (st_reg.obj[i].irq && st_reg.obj[i].valid) begin
        iid = 16'(i + 1);
      end
    end
    st_next.irq_id = st_reg.stat_irq ? STATUS_INTERRUPT_CODE : iid;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // objects come up cleared here, but software must still clear them
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg       <= '0;
      st_reg.retry <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rd_data_o   = st_reg.rd_data;
  assign tx_req_o    = st_reg.tx_req;
  assign tx_id_o     = st_reg.tx_id;
  assign tx_ext_o    = st_reg.tx_ext;
  assign tx_remote_o = st_reg.tx_remote;
  assign tx_dlc_o    = st_reg.tx_dlc;
  assign tx_data_o   = st_reg.tx_data;
  assign enabled_o   = st_reg.enable;
  assign irq_id_o    = st_reg.irq_id;

endmodule

// *** sim/cmo_core_monitor.sv ***
// checker of the message-object store, watching the core's ports only
// assumes one clock domain and the register and frame timing of the core
`timescale 1ns/1ps
module cmo_core_monitor (
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        nrst_i,
  // register port
  input wire logic [8:0]  addr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rd_data_o,
  // frame engine side
  input wire logic        rx_valid_i,
  input wire logic        tx_req_o,
  input wire logic [28:0] tx_id_o,
  input wire logic [3:0]  tx_dlc_o,
  input wire logic [63:0] tx_data_o,
  input wire logic        tx_done_i,
  input wire logic        tx_fail_i,
  input wire logic        err_valid_i,
  input wire logic        bit_err_i,
  input wire logic        bit_sent_recessive_i,
  // controller state
  input wire logic        enabled_o,
  input wire logic [15:0] irq_id_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // a status event in the read cycle wins over the clear
  wire logic evt = rx_valid_i | tx_done_i | tx_fail_i | err_valid_i | bit_err_i;

  read_idle_zero_a: assert property (!$past(rd_i) |-> rd_data_o == 32'h0)
    else $error("read data not zero outside a read answer");
  tx_fields_held_a: assert property (tx_req_o && $past(tx_req_o) |-> $stable({tx_id_o, tx_dlc_o, tx_data_o}))
    else $error("transmit fields moved during a request");
  tx_drop_done_a: assert property (tx_req_o && (tx_done_i || tx_fail_i) |=> !tx_req_o)
    else $error("transmit request held after its outcome");
  idle_when_off_a: assert property (!enabled_o && !$past(enabled_o) |-> !tx_req_o)
    else $error("transmit request while controller disabled");
  req_needs_on_a: assert property ($rose(tx_req_o) |-> $past(enabled_o))
    else $error("transmit request started while disabled");
  irq_id_range_a: assert property (irq_id_o == 16'h8000 || irq_id_o <= 16'h0020)
    else $error("interrupt id out of range");
  rx_raises_irq_a: assert property (rx_valid_i && enabled_o |-> ##2 irq_id_o != 16'h0000)
    else $error("no interrupt after a received frame");
  status_read_clear_a: assert property (rd_i && addr_i == 9'h101 && !evt |-> ##2 irq_id_o != 16'h8000)
    else $error("status interrupt not cleared by status read");
  bit_err_code_a: assert property (bit_err_i ##1 !evt ##1 (rd_i && addr_i == 9'h101)
    |=> rd_data_o[2:0] == ($past(bit_sent_recessive_i, 3) ? 3'h4 : 3'h5))
    else $error("bit error code wrong");
endmodule

bind cmo_core cmo_core_monitor mon_u (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
  .rx_valid_i(rx_valid_i), .tx_req_o(tx_req_o), .tx_id_o(tx_id_o), .tx_dlc_o(tx_dlc_o),
  .tx_data_o(tx_data_o), .tx_done_i(tx_done_i), .tx_fail_i(tx_fail_i), .err_valid_i(err_valid_i),
  .bit_err_i(bit_err_i), .bit_sent_recessive_i(bit_sent_recessive_i), .enabled_o(enabled_o),
  .irq_id_o(irq_id_o)
);

// *** sim/cmo_peer.sv ***
// behavioural frame engine peer: answers each transmit request once
// assumes the core holds its request until the answer pulse is seen
`timescale 1ns/1ps
module cmo_peer (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  // request and scenario controls
  input  wire logic       tx_req_i,
  input  wire logic       fail_i,
  input  wire logic [3:0] wait_i,
  // outcome pulses
  output logic            tx_done_o,
  output logic            tx_fail_o
);
  logic [3:0] cnt_reg;
  // wait_i cycles of arbitration, then one outcome pulse
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg   <= 4'h0;
      tx_done_o <= 1'b0;
      tx_fail_o <= 1'b0;
    end else begin
      cnt_reg   <= 4'h0;
      tx_done_o <= 1'b0;
      tx_fail_o <= 1'b0;
      if (tx_req_i && !tx_done_o && !tx_fail_o) begin
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg == wait_i) begin
          tx_done_o <= !fail_i;
          tx_fail_o <= fail_i;
        end
      end
    end
  end
endmodule

// *** sim/can_message_object_status_test.sv ***
// self-checking bench of the message-object store
// assumes the core, its checker bind and the frame engine peer
`timescale 1ns/1ps
module can_message_object_status_test;
  import cmo_pkg::*;
  logic        core_clk_i, nrst_i, wr_i, rd_i, rx_valid_i, rx_ext_i, rx_remote_i, tx_req_o, tx_ext_o;
  logic        tx_remote_o, tx_done_i, tx_fail_i, bus_off_i, err_passive_i, err_valid_i, bit_err_i;
  logic        bit_sent_recessive_i, enabled_o, peer_fail;
  logic [8:0]  addr_i;
  logic [31:0] wr_data_i, rd_data_o;
  logic [28:0] rx_id_i, tx_id_o;
  logic [63:0] rx_data_i, tx_data_o;
  logic [3:0]  rx_dlc_i, tx_dlc_o, peer_wait;
  logic [7:0]  tx_err_cnt_i, rx_err_cnt_i;
  logic [2:0]  err_code_i;
  logic [15:0] irq_id_o;
  int          err_total, samples_checked;

  cmo_core dut_u (.core_clk_i, .nrst_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .rx_valid_i,
    .rx_id_i, .rx_ext_i, .rx_remote_i, .rx_dlc_i, .rx_data_i, .tx_req_o, .tx_id_o, .tx_ext_o,
    .tx_remote_o, .tx_dlc_o, .tx_data_o, .tx_done_i, .tx_fail_i, .bus_off_i, .err_passive_i,
    .tx_err_cnt_i, .rx_err_cnt_i, .err_valid_i, .err_code_i, .bit_err_i, .bit_sent_recessive_i,
    .enabled_o, .irq_id_o);
  cmo_peer peer_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .tx_req_i(tx_req_o), .fail_i(peer_fail),
    .wait_i(peer_wait), .tx_done_o(tx_done_i), .tx_fail_o(tx_fail_i));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  // register write and read; read data stand only in the cycle after the strobe
  task automatic wr(input logic [8:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    wr_i      <= 1'b1;
    addr_i    <= a;
    wr_data_i <= v;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [8:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge core_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 chk(nm, exp, rd_data_o & m);
  endtask
  task automatic rx(input logic [28:0] id, input logic [63:0] dat);
    @(posedge core_clk_i);
    rx_valid_i <= 1'b1;
    rx_id_i    <= id;
    rx_data_i  <= dat;
    @(posedge core_clk_i);
    rx_valid_i <= 1'b0;
  endtask
  // object 32 sends; waits are bounded and sampled off the edge
  task automatic tx_run(input logic [31:0] cfg, input logic [3:0] w);
    peer_wait <= w;
    wr(9'h0F8, cfg);
    #1;
    for (int i = 0; i < 20 && tx_req_o !== 1'b1; i++) #5;
    chk("tx_id", 32'h123, {3'h0, tx_id_o});
    chk("tx_fields", {26'h0, cfg[11:8], 2'h0}, {26'h0, tx_dlc_o, tx_ext_o, tx_remote_o});
    chk("tx_data", 32'hA5A5A5A5, tx_data_o[31:0]);
    if (w > 4'h4) rchk("pend_map", 9'h102, 32'hFFFFFFFF, 32'h80000000);
    for (int i = 0; i < 30 && tx_req_o !== 1'b0; i++) #5;
  endtask

  task automatic t_rx;
    wr(9'h100, 32'h3);
    wr(9'h001, 32'h400);
    wr(9'h002, 32'h7F8);
    wr(9'h000, 32'h8A5);
    rchk("valid_map", 9'h104, 32'hFFFFFFFF, 32'h1);
    rx(29'h408, 64'h0);
    rchk("fresh_miss", 9'h103, 32'hFFFFFFFF, 32'h0);
    rchk("rx_ok", 9'h101, 32'h10, 32'h10);
    rx(29'h403, 64'h1);
    rx(29'h405, 64'h0807060504030201);
    rchk("fresh_map", 9'h103, 32'hFFFFFFFF, 32'h1);
    rchk("cfg_flags", 9'h000, 32'h6F00, 32'h6800);
    rchk("data_lo", 9'h003, 32'hFFFFFFFF, 32'h04030201);
    rchk("data_hi", 9'h004, 32'hFFFFFFFF, 32'h08070605);
    rchk("fresh_read", 9'h103, 32'hFFFFFFFF, 32'h0);
  endtask
  task automatic t_tx;
    wr(9'h0F9, 32'h123);
    wr(9'h0FB, 32'hA5A5A5A5);
    tx_run(32'h1441, 4'h8);
    rchk("pend_done", 9'h102, 32'hFFFFFFFF, 32'h0);
    rchk("tx_ok", 9'h101, 32'h8, 32'h8);
    rchk("irq_map", 9'h107, 32'h80000000, 32'h80000000);
    chk("irq_id", 32'h20, {16'h0, irq_id_o});
    wr(9'h100, 32'h1);
    rchk("ctrl", 9'h100, 32'h3, 32'h1);
    peer_fail <= 1'b1;
    tx_run(32'h1001, 4'h0);
    rchk("pend_drop", 9'h102, 32'hFFFFFFFF, 32'h0);
    chk("no_retry", 32'h0, {31'h0, tx_req_o});
    peer_fail <= 1'b0;
    // object 2 answers a remote frame by becoming pending
    wr(9'h009, 32'h123);
    wr(9'h008, 32'h409);
    @(posedge core_clk_i);
    rx_remote_i <= 1'b1;
    rx(29'h123, 64'h0);
    rx_remote_i <= 1'b0;
    rchk("responder", 9'h102, 32'hFFFFFFFF, 32'h2);
    for (int i = 0; i < 20 && tx_req_o !== 1'b0; i++) #5;
    // invalid take-data object that would otherwise match the next frame
    wr(9'h000, 32'h8A4);
    rx(29'h400, 64'h0);
    rchk("valid_off", 9'h104, 32'h1, 32'h0);
    rchk("fresh_off", 9'h103, 32'h1, 32'h0);
  endtask
  // error codes 1..6, then bit errors sending recessive and dominant
  task automatic t_err;
    for (int k = 1; k < 9; k++) begin
      @(posedge core_clk_i);
      err_valid_i          <= (k < 7);
      bit_err_i            <= (k > 6);
      err_code_i           <= k[2:0];
      bit_sent_recessive_i <= (k == 7);
      @(posedge core_clk_i);
      err_valid_i <= 1'b0;
      bit_err_i   <= 1'b0;
      rchk("lec", 9'h101, 32'h7, (k < 7) ? k : k - 3);
    end
    @(posedge core_clk_i);
    bus_off_i     <= 1'b1;
    err_passive_i <= 1'b1;
    rx_err_cnt_i  <= 8'h60;
    rchk("err_flags", 9'h101, 32'hE0, 32'hE0);
    @(posedge core_clk_i);
    rx_err_cnt_i <= 8'h5F;
    rchk("no_warn", 9'h101, 32'h40, 32'h0);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  // watchdog: the scenarios need well under 1000 cycles
  initial begin
    #20000;
    err_total++;
    finish_test;
  end
  initial begin
    {nrst_i, wr_i, rd_i, rx_valid_i, rx_ext_i, rx_remote_i, bus_off_i, err_passive_i} = '0;
    {err_valid_i, bit_err_i, bit_sent_recessive_i, peer_fail, addr_i, wr_data_i, rx_id_i} = '0;
    {rx_data_i, peer_wait, tx_err_cnt_i, rx_err_cnt_i, err_code_i} = '0;
    rx_dlc_i        = 4'h8;
    err_total       = 0;
    samples_checked = 0;
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rchk("ctrl_reset", 9'h100, 32'h3, 32'h2);
    rchk("valid_reset", 9'h104, 32'hFFFFFFFF, 32'h0);
    t_rx;
    t_tx;
    t_err;
    finish_test;
  end
endmodule
